// file: tcal_regs.svh
// Command codes, field positions, reset values and scaling constants of the telemetry calibration registers.
`ifndef TCAL_REGS_SVH
`define TCAL_REGS_SVH

// ****************************************************************
// Command codes
// ****************************************************************
`define TCAL_CMD_SENSE_OFFSET   8'hBF
`define TCAL_CMD_DIVIDER_SCALE  8'hC0
`define TCAL_CMD_TEMP_GAIN_OFS  8'hC1

// ****************************************************************
// Field positions
// ****************************************************************
`define TCAL_LOSS_MSB           15
`define TCAL_LOSS_LSB           8
`define TCAL_VOFS_SIGN          7
`define TCAL_VOFS_MAG_MSB       6
`define TCAL_INTERCEPT_MSB      14
`define TCAL_INTERCEPT_LSB      8
`define TCAL_SLOPE_MSB          7
`define TCAL_TGO_RSVD_BIT       15

// ****************************************************************
// Reset values
// ****************************************************************
`define TCAL_RST_SENSE_OFFSET   16'h0000
`define TCAL_RST_DIVIDER_SCALE  8'h00
`define TCAL_RST_TEMP_GAIN_OFS  15'h0000

// ****************************************************************
// Scaling constants
// ****************************************************************
`define TCAL_VIN_FS_MV          1600
`define TCAL_TEMP_SHIFT         9
`define TCAL_LOSS_MW_FINE       500
`define TCAL_LOSS_MW_COARSE     1000

`endif

// file: tcal_pkg.sv
// Types shared by the telemetry calibration block.
`default_nettype none
package tcal_pkg;

  // State of the input-voltage conversion sequencer.
  typedef enum logic [1:0] {
    TCAL_VIN_IDLE = 2'b01,
    TCAL_VIN_BUSY = 2'b10
  } tcal_vin_state_t;

  // State of the iterative divider.
  typedef enum logic [1:0] {
    TCAL_DIV_IDLE = 2'b01,
    TCAL_DIV_RUN  = 2'b10
  } tcal_div_state_t;

endpackage
`default_nettype wire

// file: tcal_div.sv
// Restoring unsigned divider, one quotient bit per clock.
`timescale 1ns/1ns
`default_nettype none
module tcal_div
  import tcal_pkg::*;
#(
  parameter int WD = 21,
  parameter int WS = 8
) (
  // Clock and reset.
  input  wire logic          ref_clk_in,
  input  wire logic          reset_n_in,
  // Request.
  input  wire logic          start_in,
  input  wire logic [WD-1:0] dividend_in,
  input  wire logic [WS-1:0] divisor_in,
  // Result.
  output var  logic [WD-1:0] quotient_out,
  output var  logic          done_out
);

  localparam int CW = $clog2(WD + 1);

  typedef struct packed {
    tcal_div_state_t st;
    logic [CW-1:0]   cnt;
    logic [WS:0]     rem;
    logic [WD-1:0]   shf;
    logic [WD-1:0]   quo;
    logic [WD-1:0]   dvd_hold;
    logic [WS-1:0]   dsr;
    logic            done;
  } tcal_div_reg_t;

  tcal_div_reg_t r;
  tcal_div_reg_t next_r;

  // ****************************************************************
  // Next state
  // ****************************************************************
  // A zero divisor yields all ones; the caller saturates anyway.
  always_comb begin
    logic [WS:0] rem_sh;
    rem_sh = '0;
    next_r = r;
    next_r.done = 1'b0;
    case (r.st)
      TCAL_DIV_IDLE: begin
        if (start_in) begin
          next_r.st       = TCAL_DIV_RUN;
          next_r.cnt      = CW'(WD);
          next_r.rem      = '0;
          next_r.shf      = dividend_in;
          next_r.dvd_hold = dividend_in;
          next_r.dsr      = divisor_in;
          next_r.quo      = '0;
        end
      end
      TCAL_DIV_RUN: begin
        rem_sh = {r.rem[WS-1:0], r.shf[WD-1]};
        if (rem_sh >= {1'b0, r.dsr}) begin
          next_r.rem = rem_sh - {1'b0, r.dsr};
          next_r.quo = {r.quo[WD-2:0], 1'b1};
        end else begin
          next_r.rem = rem_sh;
          next_r.quo = {r.quo[WD-2:0], 1'b0};
        end
        next_r.shf = {r.shf[WD-2:0], 1'b0};
        next_r.cnt = r.cnt - 1'b1;
        if (r.cnt == CW'(1)) begin
          next_r.st   = TCAL_DIV_IDLE;
          next_r.done = 1'b1;
        end
      end
      default: begin
        next_r.st = TCAL_DIV_IDLE;
      end
    endcase
  end

  // State register with synchronous reset.
  always_ff @(posedge ref_clk_in) begin
    if (!reset_n_in) begin
      r    <= '0;
      r.st <= TCAL_DIV_IDLE;
    end else begin
      r <= next_r;
    end
  end

  assign quotient_out = r.quo;
  assign done_out     = r.done;

  // The quotient is the exact floor of the held dividend over the divisor.
  div_result_a: assert property (@(posedge ref_clk_in) disable iff (!reset_n_in)
    r.done && (r.dsr != '0) |-> ((32'(r.quo) * 32'(r.dsr)) <= 32'(r.dvd_hold))
      && (((32'(r.quo) + 32'd1) * 32'(r.dsr)) > 32'(r.dvd_hold)))
    else $error("divider quotient is not the floor of dividend over divisor");

endmodule
`default_nettype wire

// file: tcal_top.sv
// Telemetry calibration registers with input-voltage, temperature and power-loss scaling.
`timescale 1ns/1ns
`include "tcal_regs.svh"
`default_nettype none
module tcal_top
  import tcal_pkg::*;
#(
  parameter int ADC_W = 10
) (
  // Clock and reset.
  input  wire logic             ref_clk_in,
  input  wire logic             reset_n_in,
  // Command port from the management bus engine.
  input  wire logic [7:0]       cmd_code_in,
  input  wire logic             wr_en_in,
  input  wire logic [15:0]      wr_data_in,
  input  wire logic             rd_en_in,
  output var  logic [15:0]      rd_data_out,
  output var  logic             rd_valid_out,
  // Converter samples.
  input  wire logic             vin_sample_valid_in,
  input  wire logic [ADC_W-1:0] vin_sample_in,
  input  wire logic             temp_sample_valid_in,
  input  wire logic [ADC_W-1:0] temp_sample_in,
  // Resolution select from the current-reporting logic.
  input  wire logic             total_current_lsb_select_in,
  // Reported telemetry.
  output var  logic [15:0]      vin_report_mv_out,
  output var  logic             vin_report_valid_out,
  output var  logic [ADC_W-1:0] temp_report_out,
  output var  logic             temp_report_valid_out,
  output var  logic [17:0]      input_power_loss_trim_mw_out
);

  localparam int AW = ADC_W + 1;
  localparam int DW = ADC_W + 11;
  localparam int PW = ADC_W + 8;

  typedef struct packed {
    tcal_vin_state_t  vst;
    logic [15:0]      input_sense_offset_power_loss;
    logic [7:0]       input_sense_divider_scale;
    logic [14:0]      temperature_gain_offset;
    logic [AW-1:0]    adj;
    logic [7:0]       scale_hold;
    logic             div_start;
    logic [15:0]      vin_mv;
    logic             vin_valid;
    logic [ADC_W-1:0] temp;
    logic             temp_valid;
    logic [17:0]      loss_mw;
    logic [15:0]      rd_data;
    logic             rd_valid;
  } tcal_top_reg_t;

  tcal_top_reg_t    r;
  tcal_top_reg_t    next_r;
  logic [DW-1:0]    div_quo;
  logic             div_done;

  // ****************************************************************
  // Helper functions
  // ****************************************************************
  // Sign-magnitude offset applied in sample units, clamped at zero so a
  // negative trim on a small reading never wraps to a huge voltage.
  function automatic logic [AW-1:0] tcal_vin_adjust(input logic [ADC_W-1:0] code,
                                                    input logic [7:0] ofs);
    logic [AW-1:0] mag;
    logic [AW-1:0] c;
    mag = AW'(ofs[`TCAL_VOFS_MAG_MSB:0]);
    c   = AW'(code);
    if (ofs[`TCAL_VOFS_SIGN]) begin
      tcal_vin_adjust = (c < mag) ? '0 : c - mag;
    end else begin
      tcal_vin_adjust = c + mag;
    end
  endfunction

  // Register read decode; unmapped codes and unused bits read as zero.
  function automatic logic [15:0] tcal_read_mux(input logic [7:0] cmd, input tcal_top_reg_t s);
    case (cmd)
      `TCAL_CMD_SENSE_OFFSET:  tcal_read_mux = s.input_sense_offset_power_loss;
      `TCAL_CMD_DIVIDER_SCALE: tcal_read_mux = {8'h00, s.input_sense_divider_scale};
      `TCAL_CMD_TEMP_GAIN_OFS: tcal_read_mux = {1'b0, s.temperature_gain_offset};
      default:                 tcal_read_mux = 16'h0000;
    endcase
  endfunction

  // ****************************************************************
  // Next state
  // ****************************************************************
  always_comb begin
    logic [PW-1:0] prod;
    prod = PW'(r.temperature_gain_offset[`TCAL_SLOPE_MSB:0]) * PW'(temp_sample_in);
    next_r = r;
    next_r.div_start  = 1'b0;
    next_r.vin_valid  = 1'b0;
    next_r.temp_valid = 1'b0;

    // Register writes; bit 15 of the temperature register is dropped.
    if (wr_en_in) begin
      case (cmd_code_in)
        `TCAL_CMD_SENSE_OFFSET:  next_r.input_sense_offset_power_loss = wr_data_in;
        `TCAL_CMD_DIVIDER_SCALE: next_r.input_sense_divider_scale = wr_data_in[7:0];
        `TCAL_CMD_TEMP_GAIN_OFS: next_r.temperature_gain_offset = wr_data_in[14:0];
        default:                 next_r.rd_valid = r.rd_valid;
      endcase
    end

    // Reads return the value held before a same-cycle write.
    next_r.rd_valid = rd_en_in;
    if (rd_en_in) begin
      next_r.rd_data = tcal_read_mux(cmd_code_in, r);
    end

    // Power-loss trim in milliwatts, weight chosen by the resolution select.
    if (total_current_lsb_select_in) begin
      next_r.loss_mw = 18'(r.input_sense_offset_power_loss[`TCAL_LOSS_MSB:`TCAL_LOSS_LSB])
                       * 18'(`TCAL_LOSS_MW_COARSE);
    end else begin
      next_r.loss_mw = 18'(r.input_sense_offset_power_loss[`TCAL_LOSS_MSB:`TCAL_LOSS_LSB])
                       * 18'(`TCAL_LOSS_MW_FINE);
    end

    // Temperature is slope times sample over 512 plus the intercept; the
    // slope already carries the factor two of the internal halving divider.
    if (temp_sample_valid_in) begin
      next_r.temp = ADC_W'(prod >> `TCAL_TEMP_SHIFT)
                    + ADC_W'(r.temperature_gain_offset[`TCAL_INTERCEPT_MSB:`TCAL_INTERCEPT_LSB]);
      next_r.temp_valid = 1'b1;
    end

    // Input voltage is 1.6 V times offset-corrected sample over the scale.
    // One conversion at a time: a sample arriving while busy is dropped.
    case (r.vst)
      TCAL_VIN_IDLE: begin
        if (vin_sample_valid_in) begin
          next_r.adj = tcal_vin_adjust(vin_sample_in, r.input_sense_offset_power_loss[7:0]);
          next_r.scale_hold = r.input_sense_divider_scale;
          next_r.div_start  = 1'b1;
          next_r.vst        = TCAL_VIN_BUSY;
        end
      end
      TCAL_VIN_BUSY: begin
        if (div_done) begin
          next_r.vst       = TCAL_VIN_IDLE;
          next_r.vin_valid = 1'b1;
          if ((r.scale_hold == 8'h00) || (|div_quo[DW-1:16])) begin
            next_r.vin_mv = 16'hFFFF;
          end else begin
            next_r.vin_mv = div_quo[15:0];
          end
        end
      end
      default: begin
        next_r.vst = TCAL_VIN_IDLE;
      end
    endcase
  end

  // State register with synchronous reset.
  always_ff @(posedge ref_clk_in) begin
    if (!reset_n_in) begin
      r                               <= '0;
      r.vst                           <= TCAL_VIN_IDLE;
      r.input_sense_offset_power_loss <= `TCAL_RST_SENSE_OFFSET;
      r.input_sense_divider_scale     <= `TCAL_RST_DIVIDER_SCALE;
      r.temperature_gain_offset       <= `TCAL_RST_TEMP_GAIN_OFS;
    end else begin
      r <= next_r;
    end
  end

  // ****************************************************************
  // Scaling divider
  // ****************************************************************
  // Serial division trades about two dozen cycles of latency for area.
  tcal_div #(
    .WD (DW),
    .WS (8)
  ) u_div (
    .ref_clk_in   (ref_clk_in),
    .reset_n_in   (reset_n_in),
    .start_in     (r.div_start),
    .dividend_in  (DW'(r.adj) * DW'(`TCAL_VIN_FS_MV)),
    .divisor_in   (r.scale_hold),
    .quotient_out (div_quo),
    .done_out     (div_done)
  );

  // Outputs straight from the state register.
  assign rd_data_out                  = r.rd_data;
  assign rd_valid_out                 = r.rd_valid;
  assign vin_report_mv_out            = r.vin_mv;
  assign vin_report_valid_out         = r.vin_valid;
  assign temp_report_out              = r.temp;
  assign temp_report_valid_out        = r.temp_valid;
  assign input_power_loss_trim_mw_out = r.loss_mw;

  // ****************************************************************
  // Assertions
  // ****************************************************************
  default clocking tcal_cb @(posedge ref_clk_in);
  endclocking
  default disable iff (!reset_n_in);

  trim_write_a: assert property (wr_en_in && cmd_code_in == `TCAL_CMD_SENSE_OFFSET
    |=> r.input_sense_offset_power_loss == $past(wr_data_in))
    else $error("offset register did not take the written value");

  loss_fine_a: assert property (!total_current_lsb_select_in
    |=> input_power_loss_trim_mw_out == 18'($past(r.input_sense_offset_power_loss[15:8])) * 18'd500)
    else $error("power-loss trim not weighted at half watt");

  loss_coarse_a: assert property (total_current_lsb_select_in
    |=> input_power_loss_trim_mw_out == 18'($past(r.input_sense_offset_power_loss[15:8])) * 18'd1000)
    else $error("power-loss trim not weighted at one watt");

  offset_sign_a: assert property (r.vst == TCAL_VIN_IDLE && vin_sample_valid_in
    |=> ($past(r.input_sense_offset_power_loss[7]) ? (r.adj <= AW'($past(vin_sample_in)))
                                            : (r.adj >= AW'($past(vin_sample_in)))))
    else $error("offset sign applied the wrong way");

  offset_mag_a: assert property (r.vst == TCAL_VIN_IDLE && vin_sample_valid_in
    && !r.input_sense_offset_power_loss[7]
    |=> r.adj == AW'($past(vin_sample_in)) + AW'($past(r.input_sense_offset_power_loss[6:0])))
    else $error("positive offset magnitude wrong");

  rsvd_bit_zero_a: assert property (rd_en_in && cmd_code_in == `TCAL_CMD_TEMP_GAIN_OFS
    |=> rd_valid_out && !rd_data_out[15])
    else $error("reserved temperature bit read as one");

  temp_report_a: assert property (temp_sample_valid_in
    |=> temp_report_valid_out && temp_report_out
        == ADC_W'((PW'($past(r.temperature_gain_offset[7:0])) * PW'($past(temp_sample_in))) >> 9)
         + ADC_W'($past(r.temperature_gain_offset[14:8])))
    else $error("temperature report does not match slope and intercept");

  vin_latency_a: assert property (r.vst == TCAL_VIN_IDLE && vin_sample_valid_in
    |-> ##[1:30] vin_report_valid_out)
    else $error("input voltage report not produced in time");

  scale_zero_a: assert property (vin_report_valid_out && r.scale_hold == 8'h00
    |-> vin_report_mv_out == 16'hFFFF)
    else $error("zero divider scale did not saturate the report");

endmodule
`default_nettype wire

// file: tcal_top_tb_top.sv
// Self-checking testbench for the telemetry calibration register block.
`timescale 1ns/1ns
`include "tcal_regs.svh"
`default_nettype none
module tcal_top_tb_top;
  // ****************************************************************
  // Signals
  // ****************************************************************
  logic        ref_clk_in;
  logic        reset_n_in;
  logic [7:0]  cmd_code_in;
  logic        wr_en_in;
  logic [15:0] wr_data_in;
  logic        rd_en_in;
  logic [15:0] rd_data_out;
  logic        rd_valid_out;
  logic        vin_sample_valid_in;
  logic [9:0]  vin_sample_in;
  logic        temp_sample_valid_in;
  logic [9:0]  temp_sample_in;
  logic        total_current_lsb_select_in;
  logic [15:0] vin_report_mv_out;
  logic        vin_report_valid_out;
  logic [9:0]  temp_report_out;
  logic        temp_report_valid_out;
  logic [17:0] input_power_loss_trim_mw_out;
  int          n_errors;
  int          checks_done;
  int          cycles;

  tcal_top #(.ADC_W(10)) tcal_top_inst (
    .ref_clk_in                   (ref_clk_in),
    .reset_n_in                   (reset_n_in),
    .cmd_code_in                  (cmd_code_in),
    .wr_en_in                     (wr_en_in),
    .wr_data_in                   (wr_data_in),
    .rd_en_in                     (rd_en_in),
    .rd_data_out                  (rd_data_out),
    .rd_valid_out                 (rd_valid_out),
    .vin_sample_valid_in          (vin_sample_valid_in),
    .vin_sample_in                (vin_sample_in),
    .temp_sample_valid_in         (temp_sample_valid_in),
    .temp_sample_in               (temp_sample_in),
    .total_current_lsb_select_in  (total_current_lsb_select_in),
    .vin_report_mv_out            (vin_report_mv_out),
    .vin_report_valid_out         (vin_report_valid_out),
    .temp_report_out              (temp_report_out),
    .temp_report_valid_out        (temp_report_valid_out),
    .input_power_loss_trim_mw_out (input_power_loss_trim_mw_out)
  );

  // ****************************************************************
  // Clock, timeout and closing
  // ****************************************************************
  // Free-running 250 MHz clock.
  always #2 ref_clk_in = ~ref_clk_in;

  // A hang is cut short well beyond the few hundred cycles the tests need.
  always @(posedge ref_clk_in) begin
    cycles++;
    if (cycles == 3000) begin
      n_errors++;
      complete_run();
    end
  end

  task automatic complete_run();
    $display("Comparisons %0d, mismatches %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // ****************************************************************
  // Helper tasks
  // ****************************************************************
  // Compares with case inequality so that an unknown never matches.
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // Inputs always change 1 ns after the rising edge.
  task automatic tick();
    @(posedge ref_clk_in);
    #1;
  endtask

  // One register access; a write leaves its strobe up so the next call may follow back to back.
  task automatic bus(input logic w, input logic r, input logic [7:0] cmd, input logic [15:0] d,
                     input logic [15:0] exp);
    wr_en_in = w;
    rd_en_in = r;
    cmd_code_in = cmd;
    wr_data_in = d;
    tick();
    if (r) begin
      // The valid pulse stands for the one cycle after the taking edge only.
      check("read valid", {31'h0, rd_valid_out}, 32'h1);
      check("read data", {16'h0, rd_data_out}, {16'h0, exp});
      wr_en_in = 1'b0;
      rd_en_in = 1'b0;
      tick();
    end
  endtask

  // Sends one sample; optionally a second one while busy, which must be dropped.
  task automatic vin(input logic [9:0] s, input logic [15:0] exp, input logic drop);
    wr_en_in = 1'b0;
    vin_sample_in = s;
    vin_sample_valid_in = 1'b1;
    tick();
    vin_sample_valid_in = 1'b0;
    repeat (9) tick();
    vin_sample_in = ~s;
    vin_sample_valid_in = drop;
    tick();
    vin_sample_valid_in = 1'b0;
    repeat (12) tick();
    check("vin valid early", {31'h0, vin_report_valid_out}, 32'h0);
    tick();
    check("vin valid", {31'h0, vin_report_valid_out}, 32'h1);
    check("vin value", {16'h0, vin_report_mv_out}, {16'h0, exp});
    repeat (12) begin
      tick();
      check("vin no extra", {31'h0, vin_report_valid_out}, 32'h0);
    end
  endtask

  // Two temperature samples on consecutive edges.
  task automatic temp2(input logic [9:0] a, input logic [9:0] b, input logic [9:0] ea,
                       input logic [9:0] eb);
    wr_en_in = 1'b0;
    temp_sample_in = a;
    temp_sample_valid_in = 1'b1;
    tick();
    check("temp valid a", {31'h0, temp_report_valid_out}, 32'h1);
    check("temp value a", {22'h0, temp_report_out}, {22'h0, ea});
    temp_sample_in = b;
    tick();
    temp_sample_valid_in = 1'b0;
    check("temp valid b", {31'h0, temp_report_valid_out}, 32'h1);
    check("temp value b", {22'h0, temp_report_out}, {22'h0, eb});
    tick();
    check("temp valid end", {31'h0, temp_report_valid_out}, 32'h0);
  endtask

  // Waits for the trim to settle after a register or select change.
  task automatic loss(input logic sel, input logic [17:0] exp);
    wr_en_in = 1'b0;
    total_current_lsb_select_in = sel;
    repeat (2) tick();
    check("loss trim", {14'h0, input_power_loss_trim_mw_out}, {14'h0, exp});
  endtask

  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial begin
    ref_clk_in = 1'b0;
    reset_n_in = 1'b0;
    {cmd_code_in, wr_en_in, wr_data_in, rd_en_in} = '0;
    {vin_sample_valid_in, vin_sample_in, temp_sample_valid_in, temp_sample_in} = '0;
    total_current_lsb_select_in = 1'b0;
    n_errors = 0;
    checks_done = 0;
    cycles = 0;
    repeat (4) tick();
    check("reset loss", {14'h0, input_power_loss_trim_mw_out}, 32'h0);
    reset_n_in = 1'b1;
    tick();
    // Reset values, unmapped read and the ignored top bits.
    bus(1'b0, 1'b1, `TCAL_CMD_SENSE_OFFSET, 16'h0000, 16'h0000);
    bus(1'b0, 1'b1, `TCAL_CMD_TEMP_GAIN_OFS, 16'h0000, 16'h0000);
    bus(1'b0, 1'b1, 8'hC2, 16'h0000, 16'h0000);
    bus(1'b1, 1'b0, `TCAL_CMD_TEMP_GAIN_OFS, 16'hFFFF, 16'h0000);
    bus(1'b0, 1'b1, `TCAL_CMD_TEMP_GAIN_OFS, 16'h0000, 16'h7FFF);
    bus(1'b1, 1'b0, `TCAL_CMD_DIVIDER_SCALE, 16'h1240, 16'h0000);
    bus(1'b1, 1'b0, 8'hC2, 16'h5555, 16'h0000);
    bus(1'b0, 1'b1, `TCAL_CMD_DIVIDER_SCALE, 16'h0000, 16'h0040);
    // A read in the cycle of a write returns the old contents.
    bus(1'b1, 1'b1, `TCAL_CMD_SENSE_OFFSET, 16'hA5C3, 16'h0000);
    bus(1'b0, 1'b1, `TCAL_CMD_SENSE_OFFSET, 16'h0000, 16'hA5C3);
    // Power-loss trim in both resolutions, low and full-scale byte.
    bus(1'b1, 1'b0, `TCAL_CMD_SENSE_OFFSET, 16'h0400, 16'h0000);
    loss(1'b0, 18'd2000);
    loss(1'b1, 18'd4000);
    bus(1'b1, 1'b0, `TCAL_CMD_SENSE_OFFSET, 16'hFF00, 16'h0000);
    loss(1'b1, 18'd255000);
    loss(1'b0, 18'd127500);
    // Input voltage: plain, positive and negative offset, clamp, saturation, rounding down.
    bus(1'b1, 1'b0, `TCAL_CMD_SENSE_OFFSET, 16'h0000, 16'h0000);
    vin(10'd512, 16'd12800, 1'b1);
    bus(1'b1, 1'b0, `TCAL_CMD_SENSE_OFFSET, 16'h000A, 16'h0000);
    vin(10'd512, 16'd13050, 1'b0);
    bus(1'b1, 1'b0, `TCAL_CMD_SENSE_OFFSET, 16'h048A, 16'h0000);
    vin(10'd512, 16'd12550, 1'b0);
    vin(10'd5, 16'd0, 1'b0);
    bus(1'b1, 1'b0, `TCAL_CMD_SENSE_OFFSET, 16'h0000, 16'h0000);
    bus(1'b1, 1'b0, `TCAL_CMD_DIVIDER_SCALE, 16'h0003, 16'h0000);
    vin(10'd100, 16'd53333, 1'b0);
    bus(1'b1, 1'b0, `TCAL_CMD_DIVIDER_SCALE, 16'h0001, 16'h0000);
    vin(10'd1023, 16'hFFFF, 1'b0);
    bus(1'b1, 1'b0, `TCAL_CMD_DIVIDER_SCALE, 16'h0000, 16'h0000);
    vin(10'd512, 16'hFFFF, 1'b0);
    // Temperature: slope and intercept, then both fields at full scale.
    bus(1'b1, 1'b0, `TCAL_CMD_TEMP_GAIN_OFS, 16'h05C8, 16'h0000);
    temp2(10'd100, 10'd1023, 10'd44, 10'd404);
    bus(1'b1, 1'b0, `TCAL_CMD_TEMP_GAIN_OFS, 16'h7FFF, 16'h0000);
    temp2(10'd1023, 10'd0, 10'd636, 10'd127);
    // A second reset in mid-run restores the registers.
    reset_n_in = 1'b0;
    repeat (2) tick();
    reset_n_in = 1'b1;
    tick();
    bus(1'b0, 1'b1, `TCAL_CMD_TEMP_GAIN_OFS, 16'h0000, 16'h0000);
    complete_run();
  end
endmodule
`default_nettype wire
